//--- fah_angle_hold.sv
// Voltage angle hold supervisor for directional and distance protection stages.
//
// Overview of operation
// - Undervoltage only when all used voltages below threshold.
// - Optional current qualification needs any phase overcurrent.
// - Reference amplitude equals threshold while hold active.
// - Track healthy angles; freeze pre-fault angles on activation.
// - Status output high throughout active hold.
// - Definite-time timer limits hold duration.
// - After expiry, signal stages to go non-directional.
// - Block input sampled per cycle; prevents or cancels hold.
// - Fixed system frequency used unless forced tracking.
// - Forced tracking without voltage uses phase C frequency.
// - ON/OFF events for undervoltage and overcurrent changes.
// - Events for enable, tracking, hold use, hold blocked.
`timescale 1ns/100ps
module fah_angle_hold #(
  parameter int unsigned TICK_LEN = fah_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic                                      clk,
  input  wire logic                                      rst_b,
  // Configuration.
  input  wire logic                                      angle_hold_enable,
  input  wire logic                                      current_qual_enable,
  input  wire logic                                      forced_current_freq_follow,
  input  wire logic [fah_pkg::VOLT_W-1:0]                hold_activation_threshold,
  input  wire logic [fah_pkg::CURR_W-1:0]                current_pickup,
  input  wire logic [fah_pkg::CNT_W-1:0]                 hold_max_duration,
  input  wire logic [fah_pkg::FREQ_W-1:0]                fixed_freq,
  // Measurements and block input.
  input  wire fah_pkg::fah_volt_t                        volt_in,
  input  wire logic [fah_pkg::NUM_PH-1:0][fah_pkg::CURR_W-1:0] phase_current,
  input  wire logic [fah_pkg::FREQ_W-1:0]                phase_c_current_freq,
  input  wire logic                                      hold_block,
  // Outputs to protection stages.
  output fah_pkg::fah_ref_t                              ref_out,
  output logic                                           hold_active,
  output logic                                           nondir_fallback,
  output logic                                           freq_from_current,
  output logic [fah_pkg::FREQ_W-1:0]                     sample_freq,
  output logic [fah_pkg::EV_W-1:0]                       hold_event_group
);
  import fah_pkg::*;

  // ***************************************************************************
  // Program cycle tick
  // ***************************************************************************
  logic [CNT_W-1:0] tick_cnt;
  logic [CNT_W-1:0] next_tick_cnt;
  logic             tick;
  logic             next_tick;

  always_comb begin
    next_tick     = 1'b0;
    next_tick_cnt = tick_cnt + 32'h1;
    if (tick_cnt >= TICK_LEN - 1) begin
      next_tick_cnt = '0;
      next_tick     = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      tick     <= next_tick;
    end
  end

  // ***************************************************************************
  // Criteria
  // ***************************************************************************
  logic [NUM_PH-1:0] ph_low;
  logic [NUM_PH-1:0] ph_over;

  for (genvar g = 0; g < NUM_PH; g++) begin : g_ph
    assign ph_low[g]  = !volt_in.used[g] || (volt_in.mag[g] < hold_activation_threshold);
    assign ph_over[g] = phase_current[g] > current_pickup;
  end

  logic uv_now;
  logic oc_now;
  logic crit_now;
  assign uv_now   = angle_hold_enable && (|volt_in.used) && (&ph_low);
  assign oc_now   = angle_hold_enable && (|ph_over);
  assign crit_now = uv_now && (!current_qual_enable || oc_now);

  // ***************************************************************************
  // Hold state machine
  // ***************************************************************************
  fah_state_t                    state;
  fah_state_t                    next_state;
  logic [CNT_W-1:0]              hold_ticks;
  logic [CNT_W-1:0]              next_hold_ticks;
  logic                          blk;
  logic                          next_blk;
  logic [NUM_PH-1:0][ANGLE_W-1:0] healthy_ang;
  logic [NUM_PH-1:0][ANGLE_W-1:0] next_healthy_ang;
  fah_ref_t                      next_ref_out;
  logic                          next_hold_active;
  logic                          next_fallback;
  logic                          next_track;
  logic [FREQ_W-1:0]             next_sample_freq;
  logic                          en_d;
  logic                          uv_d;
  logic                          oc_d;
  logic [EV_W-1:0]               next_events;

  always_comb begin
    next_state       = state;
    next_hold_ticks  = hold_ticks;
    next_blk         = tick ? hold_block : blk;
    next_healthy_ang = healthy_ang;
    if (!uv_now) begin
      next_healthy_ang = volt_in.ang;
    end
    case (state)
      FAH_IDLE: begin
        if (tick && crit_now && !next_blk) begin
          next_state      = FAH_HOLD;
          next_hold_ticks = '0;
        end
      end
      FAH_HOLD: begin
        if (!crit_now || next_blk) begin
          next_state = FAH_IDLE;
        end else if (tick) begin
          next_hold_ticks = hold_ticks + 32'h1;
          if (hold_ticks + 32'h1 >= hold_max_duration) begin
            next_state = FAH_EXPIRED;
          end
        end
      end
      FAH_EXPIRED: begin
        if (!crit_now) begin
          next_state = FAH_IDLE;
        end
      end
      default: begin
        next_state = FAH_IDLE;
      end
    endcase
    next_hold_active = (next_state == FAH_HOLD);
    next_fallback    = (next_state == FAH_EXPIRED);
    next_ref_out.valid = next_hold_active;
    next_ref_out.mag   = next_hold_active ? hold_activation_threshold : '0;
    next_ref_out.ang   = (state == FAH_HOLD) ? ref_out.ang : healthy_ang;
    next_track       = forced_current_freq_follow && uv_now;
    next_sample_freq = next_track ? phase_c_current_freq : fixed_freq;
    next_events = EV_NONE;
    next_events[EV_ENABLED]   = angle_hold_enable && !en_d;
    next_events[EV_DISABLED]  = !angle_hold_enable && en_d;
    next_events[EV_UV_ON]     = uv_now && !uv_d;
    next_events[EV_UV_OFF]    = !uv_now && uv_d;
    next_events[EV_OC_ON]     = oc_now && !oc_d;
    next_events[EV_OC_OFF]    = !oc_now && oc_d;
    next_events[EV_TRACK_ON]  = next_track && !freq_from_current;
    next_events[EV_TRACK_OFF] = !next_track && freq_from_current;
    next_events[EV_HOLD_ON]   = next_hold_active && !hold_active;
    next_events[EV_HOLD_OFF]  = !next_hold_active && hold_active;
    next_events[EV_BLK_ON]    = next_blk && !blk;
    next_events[EV_BLK_OFF]   = !next_blk && blk;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state             <= FAH_IDLE;
      hold_ticks        <= '0;
      blk               <= 1'b0;
      healthy_ang       <= '0;
      ref_out           <= '0;
      hold_active       <= 1'b0;
      nondir_fallback   <= 1'b0;
      freq_from_current <= 1'b0;
      sample_freq       <= '0;
      en_d              <= 1'b0;
      uv_d              <= 1'b0;
      oc_d              <= 1'b0;
      hold_event_group  <= EV_NONE;
    end else begin
      state             <= next_state;
      hold_ticks        <= next_hold_ticks;
      blk               <= next_blk;
      healthy_ang       <= next_healthy_ang;
      ref_out           <= next_ref_out;
      hold_active       <= next_hold_active;
      nondir_fallback   <= next_fallback;
      freq_from_current <= next_track;
      sample_freq       <= next_sample_freq;
      en_d              <= angle_hold_enable;
      uv_d              <= uv_now;
      oc_d              <= oc_now;
      hold_event_group  <= next_events;
    end
  end

  // ***************************************************************************
  // Checks
  // ***************************************************************************
  // Ticks counted while the hold is up, kept apart from the state machine's own timer.
  logic [CNT_W-1:0] chk_ticks;
  logic [CNT_W-1:0] next_chk_ticks;

  always_comb begin
    next_chk_ticks = '0;
    if (hold_active) begin
      next_chk_ticks = tick ? chk_ticks + 32'h1 : chk_ticks;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chk_ticks <= '0;
    end else begin
      chk_ticks <= next_chk_ticks;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_start;
    tick && crit_now && !hold_block && state == FAH_IDLE;
  endsequence

  sequence s_last_tick;
    hold_active && tick && crit_now && !hold_block && (chk_ticks + 32'h1 >= hold_max_duration);
  endsequence

  sequence s_track;
    forced_current_freq_follow && uv_now;
  endsequence

  chk_uv_needs_all: assert property (hold_active |-> $past((&ph_low) && (|volt_in.used)))
    else $error("hold without all used phases low");
  chk_qual_current: assert property (hold_active && $past(current_qual_enable) |-> $past(oc_now))
    else $error("hold without overcurrent");
  chk_ref_amp: assert property (hold_active |-> ref_out.mag == $past(hold_activation_threshold))
    else $error("reference amplitude wrong");
  chk_ang_frozen: assert property (hold_active && $past(hold_active) |-> $stable(ref_out.ang))
    else $error("angle moved during hold");
  chk_hold_start: assert property (s_start |=> hold_active)
    else $error("hold did not start");
  chk_timer_end: assert property (hold_active |-> chk_ticks < hold_max_duration)
    else $error("hold exceeded timer");
  chk_fallback: assert property (s_last_tick |=> nondir_fallback && !hold_active)
    else $error("no fallback after expiry");
  chk_block_cancel: assert property (tick && hold_block |=> !hold_active)
    else $error("hold despite block");
  chk_fixed_freq: assert property (!freq_from_current && $past(rst_b) |-> sample_freq == $past(fixed_freq))
    else $error("fixed frequency not used");
  chk_track_freq: assert property (s_track |=> sample_freq == $past(phase_c_current_freq))
    else $error("tracking not used");
  chk_uv_events: assert property ($rose(uv_now) |=> hold_event_group[EV_UV_ON])
    else $error("missing undervoltage on event");
  chk_hold_events: assert property ($fell(hold_active) |-> hold_event_group[EV_HOLD_OFF])
    else $error("missing hold off event");
  chk_crit_drop: assert property (hold_active && !crit_now |=> !hold_active)
    else $error("hold outlived criteria");
  chk_timer_restart: assert property ($rose(hold_active) |-> hold_ticks == '0)
    else $error("timer not restarted");

endmodule : fah_angle_hold

//--- fah_angle_hold_tb.sv
// Self-checking testbench for the fault voltage angle hold block.
`timescale 1ns/100ps
module fah_angle_hold_tb;
  import fah_pkg::*;
  localparam int unsigned TL = 10;
  logic                          clk = 1'b0, rst_b = 1'b0, hold_block = 1'b0;
  logic                          angle_hold_enable = 1'b0, current_qual_enable = 1'b0;
  logic                          forced_current_freq_follow = 1'b0;
  logic [VOLT_W-1:0]             hold_activation_threshold = 16'h03E8;
  logic [CURR_W-1:0]             current_pickup = 16'h0200;
  logic [CNT_W-1:0]              hold_max_duration = 32'h00000002;
  logic [FREQ_W-1:0]             fixed_freq = 16'h0032, phase_c_current_freq = 16'h002E, sample_freq;
  fah_volt_t                     volt_in = '0;
  logic [NUM_PH-1:0][CURR_W-1:0] phase_current = '0;
  fah_ref_t                      ref_out;
  logic                          hold_active, nondir_fallback, freq_from_current;
  logic [EV_W-1:0]               hold_event_group, ev_seen = EV_NONE;
  logic [1:0]                    mode;
  logic [NUM_PH-1:0][ANGLE_W-1:0] pre_ang;
  integer                        seed = 90221;
  int                            bad_count = 0, checked = 0, n;

  fah_angle_hold #(.TICK_LEN(TL)) fah_angle_hold_i (
    .clk, .rst_b, .angle_hold_enable, .current_qual_enable, .forced_current_freq_follow,
    .hold_activation_threshold, .current_pickup, .hold_max_duration, .fixed_freq, .volt_in,
    .phase_current, .phase_c_current_freq, .hold_block, .ref_out, .hold_active,
    .nondir_fallback, .freq_from_current, .sample_freq, .hold_event_group);
  fah_stage_model fah_stage_model_i (.clk, .rst_b, .ref_in(ref_out), .hold_active, .nondir_fallback, .mode);

  always #2 clk = ~clk;
  always @(posedge clk) if (rst_b) ev_seen <= ev_seen | hold_event_group;

  function automatic logic [FREQ_W-1:0] exp_freq(input logic follow, input logic uv);
    return (follow && uv) ? phase_c_current_freq : fixed_freq;
  endfunction : exp_freq

  task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  // Drives all phases below or above the threshold; phase at_thr sits on it, phase at_max at full scale.
  task automatic set_volts(input logic low, input logic [NUM_PH-1:0] used, input int at_thr, input int at_max,
                           input logic new_ang);
    @(posedge clk);
    for (int i = 0; i < NUM_PH; i++) begin
      if (i == at_thr) begin
        volt_in.mag[i] <= hold_activation_threshold;
      end else if (i == at_max) begin
        volt_in.mag[i] <= 16'hFFFF;
      end else begin
        volt_in.mag[i] <= low ? VOLT_W'($unsigned($random(seed)) % hold_activation_threshold)
                              : hold_activation_threshold + VOLT_W'($unsigned($random(seed)) % 32'h1F4) + 16'h0001;
      end
      if (new_ang) begin
        volt_in.ang[i] <= ANGLE_W'($random(seed));
      end
    end
    volt_in.used <= used;
  endtask : set_volts

  task automatic wait_hold(input logic v);
    n = 0;
    while (hold_active !== v && n < 4 * TL) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_hold

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // ***************************************************************************
  // Stimulus and checks
  // ***************************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 chk_val("outputs after reset", 0, {hold_active, nondir_fallback, freq_from_current, hold_event_group});
    @(posedge clk);
    angle_hold_enable <= 1'b1;
    forced_current_freq_follow <= 1'b1;
    hold_activation_threshold <= 16'h00C8 + VOLT_W'($unsigned($random(seed)) % 32'h12C1);
    hold_max_duration <= 32'h2 + ($unsigned($random(seed)) % 32'h3);
    fixed_freq <= FREQ_W'($random(seed));
    phase_c_current_freq <= FREQ_W'($random(seed));
    set_volts(1'b1, 3'b111, 1, -1, 1'b1);
    repeat (3 * TL) @(posedge clk);
    #1 chk_val("hold with one phase at threshold", 0, hold_active);
    chk_val("sample_freq healthy", exp_freq(1'b1, 1'b0), sample_freq);
    set_volts(1'b0, 3'b111, -1, -1, 1'b1);
    repeat (2 * TL) @(posedge clk);
    pre_ang = volt_in.ang;
    set_volts(1'b1, 3'b011, -1, 2, 1'b0);
    wait_hold(1'b1);
    chk_val("hold with unused phase high", 1, hold_active);
    chk_val("ref valid", 1, ref_out.valid);
    chk_val("ref amplitude", hold_activation_threshold, ref_out.mag);
    chk_val("sample_freq fault", exp_freq(1'b1, 1'b1), sample_freq);
    chk_val("freq_from_current", 1, freq_from_current);
    @(posedge clk);
    volt_in.ang <= ~pre_ang;
    repeat (3) @(posedge clk);
    #1 chk_val("ref angles frozen", pre_ang, ref_out.ang);
    chk_val("stage mode held", 2'h1, mode);
    n = 4;
    while (hold_active === 1'b1 && n < 80 * TL) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_val("hold length", hold_max_duration * TL, n);
    chk_val("fallback after expiry", 1, nondir_fallback);
    @(posedge clk);
    #1 chk_val("stage mode fallback", 2'h2, mode);
    set_volts(1'b0, 3'b111, -1, -1, 1'b1);
    repeat (2 * TL) @(posedge clk);
    #1 chk_val("fallback released", 0, nondir_fallback);
    @(posedge clk);
    current_qual_enable <= 1'b1;
    current_pickup <= 16'h0100 + CURR_W'($unsigned($random(seed)) % 32'h0F00);
    set_volts(1'b1, 3'b111, -1, -1, 1'b1);
    phase_current[0] <= current_pickup;
    repeat (3 * TL) @(posedge clk);
    #1 chk_val("hold without overcurrent", 0, hold_active);
    @(posedge clk);
    phase_current[2] <= current_pickup + 16'h0001;
    wait_hold(1'b1);
    chk_val("hold with overcurrent", 1, hold_active);
    @(posedge clk);
    hold_block <= 1'b1;
    wait_hold(1'b0);
    chk_val("hold cancelled by block", 0, hold_active);
    repeat (2 * TL) @(posedge clk);
    #1 chk_val("hold stays blocked", 0, hold_active);
    @(posedge clk);
    hold_block <= 1'b0;
    wait_hold(1'b1);
    chk_val("hold restarts", 1, hold_active);
    set_volts(1'b0, 3'b111, -1, -1, 1'b1);
    wait_hold(1'b0);
    chk_val("hold ends on recovery", 0, hold_active);
    chk_val("no fallback on recovery", 0, nondir_fallback);
    @(posedge clk);
    phase_current <= '0;
    repeat (TL + 2) @(posedge clk);
    #1 chk_val("sample_freq recovered", exp_freq(1'b1, 1'b0), sample_freq);
    @(posedge clk);
    angle_hold_enable <= 1'b0;
    forced_current_freq_follow <= 1'b0;
    repeat (2 * TL) @(posedge clk);
    #1 chk_val("events seen", 12'hFFF, ev_seen);
    complete_run();
  end

  initial begin
    #16000;
    bad_count++;
    complete_run();
  end
endmodule : fah_angle_hold_tb

//--- fah_pkg.sv
// Package of constants and carrier types for the fault voltage angle hold block.
package fah_pkg;

  // ***************************************************************************
  // Widths and timing
  // ***************************************************************************
  localparam int unsigned VOLT_W       = 16;
  localparam int unsigned CURR_W       = 16;
  localparam int unsigned ANGLE_W      = 16;
  localparam int unsigned FREQ_W       = 16;
  localparam int unsigned NUM_PH       = 3;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned TICK_US      = 10000;
  localparam int unsigned TICK_CYCLES  = CLK_MHZ * TICK_US;
  localparam int unsigned HOLD_MIN_TICKS = 2;
  localparam int unsigned HOLD_MAX_TICKS = 5000;
  localparam int unsigned THR_MIN_CV   = 200;
  localparam int unsigned THR_MAX_CV   = 5000;
  localparam logic [2:0]  PH_C_IDX     = 3'h2;

  // ***************************************************************************
  // Event bit positions
  // ***************************************************************************
  localparam int unsigned EV_ENABLED      = 0;
  localparam int unsigned EV_DISABLED     = 1;
  localparam int unsigned EV_UV_ON        = 2;
  localparam int unsigned EV_UV_OFF       = 3;
  localparam int unsigned EV_OC_ON        = 4;
  localparam int unsigned EV_OC_OFF       = 5;
  localparam int unsigned EV_TRACK_ON     = 6;
  localparam int unsigned EV_TRACK_OFF    = 7;
  localparam int unsigned EV_HOLD_ON      = 8;
  localparam int unsigned EV_HOLD_OFF     = 9;
  localparam int unsigned EV_BLK_ON       = 10;
  localparam int unsigned EV_BLK_OFF      = 11;
  localparam int unsigned EV_W            = 12;

  typedef enum logic [1:0] {
    FAH_IDLE    = 2'b00,
    FAH_HOLD    = 2'b01,
    FAH_EXPIRED = 2'b10
  } fah_state_t;

  typedef struct packed {
    logic [NUM_PH-1:0][VOLT_W-1:0]  mag;
    logic [NUM_PH-1:0][ANGLE_W-1:0] ang;
    logic [NUM_PH-1:0]              used;
  } fah_volt_t;

  typedef struct packed {
    logic [VOLT_W-1:0]              mag;
    logic [NUM_PH-1:0][ANGLE_W-1:0] ang;
    logic                           valid;
  } fah_ref_t;

  localparam logic [EV_W-1:0] EV_NONE = 12'h000;

endpackage : fah_pkg

//--- fah_stage_model.sv
// Behavioural model of the directional and distance stages fed by the hold block.
`timescale 1ns/100ps
module fah_stage_model (
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Supervisor outputs.
  input  wire fah_pkg::fah_ref_t ref_in,
  input  wire logic              hold_active,
  input  wire logic              nondir_fallback,
  // Operating mode: 0 live voltage, 1 held reference, 2 non-directional.
  output logic [1:0]             mode
);
  import fah_pkg::*;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode <= 2'h0;
    end else if (nondir_fallback) begin
      mode <= 2'h2;
    end else if (hold_active && ref_in.valid) begin
      mode <= 2'h1;
    end else begin
      mode <= 2'h0;
    end
  end
endmodule : fah_stage_model
